// *** design/kb_link_top.sv ***
/*
 keyboard end of the bit-serial request/acknowledge link, with an event queue
 that software fills over classic wishbone, and a masked interrupt.
 assumes host_ack_i is asynchronous and the host answers each request low.
*/
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
module kb_link_top
	import kb_link_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES   = kb_link_pkg::REQUEST_TO_ACK_CYCLES,
	parameter int unsigned REQ_SETUP_CYCLES = kb_link_pkg::DATA_TO_REQUEST_CYCLES,
	parameter int unsigned DEPTH            = kb_link_pkg::QUEUE_DEPTH
)
(
	// clock, reset, enable
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	// register bus
	input  kb_link_pkg::wb_req_s   wb_i,
	output logic                   wb_ack_o,
	output logic [31:0]            wb_dat_o,
	// interrupt
	output logic                   irq_o,
	// link pins
	input  wire logic              host_ack_i,
	output logic                   kb_request_o,
	output logic                   kb_serial_data_o
);
	typedef enum {
		ST_IDLE,
		ST_SETUP,
		ST_WAIT_FALL,
		ST_WAIT_RISE
	} link_state_e;
	localparam int unsigned PTR_W = $clog2(DEPTH);
	localparam int unsigned TMO_W = $clog2(TIMEOUT_CYCLES + 1);
	localparam int unsigned SET_W = $clog2(REQ_SETUP_CYCLES + 1);
	localparam int unsigned BIT_W = $clog2(WORD_BITS);
	// serial level of one bit of the word; the stop position reads low
	function automatic logic word_bit(input logic [7:0] w, input logic [BIT_W-1:0] idx);
		logic b;
		b = 1'b0;
		if (idx < BIT_W'(DATA_BITS))
			b = w[idx[2:0]];
		return b;
	endfunction : word_bit
	// bus access decode
	logic bus_req;
	logic bus_wr;
	logic bus_rd;
	assign bus_req = wb_i.cyc & wb_i.stb & ~wb_ack_o;
	assign bus_wr  = bus_req & wb_i.we & wb_i.sel[0];
	assign bus_rd  = bus_req & ~wb_i.we;
	// acknowledge pin
	logic ack_level;
	logic ack_rise;
	logic ack_fall;
	kb_ack_sync u_ack_sync
	(
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.pin_i   (host_ack_i),
		.level_o (ack_level),
		.rise_o  (ack_rise),
		.fall_o  (ack_fall)
	);
	// control register
	logic [1:0] ctrl_q;
	logic       dead_req_q;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_q <= CTRL_RESET;
		else if (ce_i && bus_wr && wb_i.adr == REG_CTRL)
			ctrl_q <= wb_i.dat[1:0];
	end
	// event queue
	kb_event_s            queue_mem [DEPTH];
	logic [PTR_W-1:0]     wr_ptr_q;
	logic [PTR_W-1:0]     rd_ptr_q;
	logic [PTR_W:0]       count_q;
	logic                 q_full;
	logic                 q_empty;
	logic                 push;
	logic                 pop;
	logic                 push_try;
	kb_event_s            push_ev;
	assign q_full   = count_q == (PTR_W+1)'(DEPTH);
	assign q_empty  = count_q == '0;
	assign push_ev  = kb_event_s'(wb_i.dat[7:0]);
	assign push_try = ce_i & bus_wr & (wb_i.adr == REG_EVENT) &
		(wb_i.dat[7:0] != CODE_OVERFLOW) & (wb_i.dat[7:0] != CODE_DEAD);
	assign push     = push_try & ~q_full;
	always_ff @(posedge clk_i)
	begin
		if (push)
			queue_mem[wr_ptr_q] <= push_ev;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end
		else if (ce_i)
		begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end
	// pending reserved reports; a new request wins over the clear at start
	logic ovf_pend_q;
	logic start_ovf;
	logic start_dead;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ovf_pend_q <= 1'b0;
			dead_req_q <= 1'b0;
		end
		else if (ce_i)
		begin
			ovf_pend_q <= (ovf_pend_q & ~start_ovf) | (push_try & q_full);
			dead_req_q <= (dead_req_q & ~start_dead) |
				(bus_wr & (wb_i.adr == REG_CTRL) & wb_i.dat[CTRL_DEAD_POS]);
		end
	end
	// link sequencer
	link_state_e          state_q;
	logic [7:0]           word_q;
	logic [BIT_W-1:0]     bit_q;
	logic [TMO_W-1:0]     tmo_q;
	logic [SET_W-1:0]     setup_q;
	logic                 can_start;
	logic                 tmo_hit;
	logic                 ev_sent;
	logic                 ev_tmo;
	// dead report first, then overflow, then queued keys
	assign can_start  = (state_q == ST_IDLE) & ctrl_q[CTRL_EN_POS] & ce_i;
	assign start_dead = can_start & dead_req_q;
	assign start_ovf  = can_start & ~dead_req_q & ovf_pend_q;
	assign pop        = can_start & ~dead_req_q & ~ovf_pend_q & ~q_empty;
	assign tmo_hit    = tmo_q == TMO_W'(TIMEOUT_CYCLES - 1);
	assign ev_sent    = ce_i & (state_q == ST_WAIT_RISE) & ack_rise & (bit_q == BIT_W'(WORD_BITS - 1));
	assign ev_tmo     = ce_i & (state_q == ST_WAIT_FALL) & ~ack_fall & tmo_hit;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q          <= ST_IDLE;
			word_q           <= '0;
			bit_q            <= '0;
			setup_q          <= '0;
			kb_request_o     <= 1'b1;
			kb_serial_data_o <= 1'b1;
		end
		else if (ce_i)
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (start_dead || start_ovf || pop)
					begin
						word_q           <= start_dead ? CODE_DEAD : start_ovf ? CODE_OVERFLOW : queue_mem[rd_ptr_q];
						bit_q            <= '0;
						setup_q          <= '0;
						kb_serial_data_o <= start_dead ? CODE_DEAD[0] : start_ovf ? CODE_OVERFLOW[0] :
							queue_mem[rd_ptr_q][0];
						state_q          <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					if (setup_q == SET_W'(REQ_SETUP_CYCLES - 1))
					begin
						kb_request_o <= 1'b0;
						state_q      <= ST_WAIT_FALL;
					end
					else
						setup_q <= setup_q + 1'b1;
				end
				ST_WAIT_FALL:
				begin
					if (ack_fall)
					begin
						kb_request_o <= 1'b1;
						if (bit_q == BIT_W'(WORD_BITS - 1))
							kb_serial_data_o <= 1'b1;
						state_q <= ST_WAIT_RISE;
					end
					else if (tmo_hit)
					begin
						kb_request_o     <= 1'b1;
						kb_serial_data_o <= word_q[0];
						bit_q            <= '0;
						setup_q          <= '0;
						state_q          <= ST_SETUP;
					end
				end
				ST_WAIT_RISE:
				begin
					if (ack_rise)
					begin
						if (bit_q == BIT_W'(WORD_BITS - 1))
						begin
							kb_serial_data_o <= 1'b1;
							state_q          <= ST_IDLE;
						end
						else
						begin
							bit_q            <= bit_q + 1'b1;
							kb_serial_data_o <= word_bit(word_q, bit_q + 1'b1);
							setup_q          <= '0;
							state_q          <= ST_SETUP;
						end
					end
				end
				default:
				begin
					state_q      <= ST_IDLE;
					kb_request_o <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tmo_q <= '0;
		else if (ce_i)
		begin
			if (state_q != ST_WAIT_FALL || ack_fall || tmo_hit)
				tmo_q <= '0;
			else
				tmo_q <= tmo_q + 1'b1;
		end
	end

	// interrupt status, read clears; a new event wins over the clear
	logic [IRQ_BITS-1:0] irq_stat_q;
	logic [IRQ_BITS-1:0] irq_mask_q;
	logic [IRQ_BITS-1:0] irq_set;
	logic                stat_rd;

	assign irq_set = {push_try & q_full, ev_tmo, ev_sent};
	assign stat_rd = ce_i & bus_rd & (wb_i.adr == REG_IRQ_STAT);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_stat_q <= '0;
		else if (ce_i)
			irq_stat_q <= (irq_stat_q & ~{IRQ_BITS{stat_rd}}) | irq_set;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_mask_q <= IRQ_MASK_RESET;
		else if (ce_i && bus_wr && wb_i.adr == REG_IRQ_MASK)
			irq_mask_q <= wb_i.dat[IRQ_BITS-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else if (ce_i)
			irq_o <= |(irq_stat_q & irq_mask_q);
	end

	// bus answer: one wait state, unmapped reads give zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else if (ce_i)
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= '0;
			if (bus_rd)
			begin
				case (wb_i.adr)
					REG_CTRL:     wb_dat_o <= {30'h0, ctrl_q};
					REG_STATUS:   wb_dat_o <= {4'(count_q), 12'h0, 7'h0, ack_level, 3'h0, q_full, q_empty,
						state_q != ST_IDLE, 1'b0, ovf_pend_q};
					REG_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_q};
					REG_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_q};
					default:      wb_dat_o <= '0;
				endcase
			end
		end
	end

endmodule : kb_link_top

// *** design/kb_link_pkg.sv ***
/*
 package for the keyboard serial handshake link: timing counts, register map,
 reserved codes and the bus request carrier.
 assumes a 20 MHz system clock and a 32-bit classic wishbone master.
*/
package kb_link_pkg;

	// system clock
	localparam int unsigned CLK_HZ = 20_000_000;

	// word layout
	localparam int unsigned WORD_BITS = 9;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned KEY_BITS  = 7;
	localparam int unsigned MAKE_POS  = 7;

	// link timing, figures in their own units
	localparam int unsigned T_REQUEST_TO_ACK_MS     = 250;
	localparam int unsigned T_ACK_HIGH_TO_REQUEST_MS = 1;
	localparam int unsigned T_DATA_TO_REQUEST_NS    = 0;

	// longest wait for the acknowledge, rounded down
	localparam int unsigned REQUEST_TO_ACK_CYCLES = T_REQUEST_TO_ACK_MS * (CLK_HZ / 1000);
	// longest ack-high to request-low gap, rounded down
	localparam int unsigned ACK_HIGH_TO_REQUEST_CYCLES = T_ACK_HIGH_TO_REQUEST_MS * (CLK_HZ / 1000);
	// least data setup before request low, rounded up, at least one cycle
	localparam int unsigned DATA_TO_REQUEST_CYCLES =
		((T_DATA_TO_REQUEST_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1) ? 1 :
		(T_DATA_TO_REQUEST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// reserved codes
	localparam logic [7:0] CODE_OVERFLOW = 8'hfe;
	localparam logic [7:0] CODE_DEAD     = 8'hff;

	// event queue
	localparam int unsigned QUEUE_DEPTH = 8;

	// register byte addresses
	localparam logic [7:0] REG_EVENT    = 8'h00;
	localparam logic [7:0] REG_CTRL     = 8'h04;
	localparam logic [7:0] REG_STATUS   = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;

	// control fields
	localparam int unsigned CTRL_EN_POS   = 0;
	localparam int unsigned CTRL_DEAD_POS = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h1;

	// interrupt fields
	localparam int unsigned IRQ_BITS     = 3;
	localparam int unsigned IRQ_SENT_POS = 0;
	localparam int unsigned IRQ_TMO_POS  = 1;
	localparam int unsigned IRQ_OVF_POS  = 2;
	localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;

	// key event
	typedef struct packed {
		logic       make;
		logic [6:0] key;
	} kb_event_s;

	// classic wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} wb_req_s;

endpackage : kb_link_pkg

// *** design/kb_ack_sync.sv ***
/*
 two-flop synchroniser with edge detection for the acknowledge pin.
 assumes the pin idles high and is asynchronous to clk_i.
*/
module kb_ack_sync
(
	// clock, reset, enable
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// pin and decoded level
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);

	logic meta_q;
	logic sync_q;
	logic last_q;

	// first flop feeds only the second
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			last_q <= 1'b1;
		end
		else if (ce_i)
		begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level_o = sync_q;
	assign rise_o  = ce_i & sync_q & ~last_q;
	assign fall_o  = ce_i & ~sync_q & last_q;

endmodule : kb_ack_sync

// *** tb/kb_link_chk.sv ***
/*
 pin-level checks for the keyboard end of the link and its register bus.
 assumes it is bound into kb_link_top.
*/
module kb_link_chk
	import kb_link_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = 200
)
(
	// clock, reset, enable
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            ce_i,
	// register bus and interrupt
	input  kb_link_pkg::wb_req_s wb_i,
	input  wire logic            wb_ack_o,
	input  wire logic            irq_o,
	// link pins
	input  wire logic            host_ack_i,
	input  wire logic            kb_request_o,
	input  wire logic            kb_serial_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	int unsigned low_q;
	// a counter, since the wait is far too long to unroll
	always_ff @(posedge clk_i)
		if (rst_i || kb_request_o)
			low_q <= 0;
		else
			low_q <= low_q + 1;
	a_ack_one_pulse:
		assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("bus ack held too long");
	a_bus_answer:
		assert property (wb_i.cyc && wb_i.stb && !wb_ack_o && ce_i |=> wb_ack_o) else $error("bus not answered");
	a_req_on_ackfall:
		assert property ($fell(host_ack_i) |-> ##[1:6] kb_request_o) else $error("request not raised");
	a_req_timeout:
		assert property (low_q <= TIMEOUT_CYCLES + 2) else $error("request low past timeout");
	a_data_stable_low:
		assert property (!kb_request_o && !$past(kb_request_o) |-> $stable(kb_serial_data_o))
		else $error("data moved under request");
	a_data_setup:
		assert property ($fell(kb_request_o) |-> $stable(kb_serial_data_o)) else $error("data not set up");
	a_data_fall_ackhigh:
		assert property ($fell(kb_serial_data_o) |-> host_ack_i) else $error("data fell with ack low");
	a_stop_release:
		assert property ($rose(kb_serial_data_o) && !host_ack_i |-> $rose(kb_request_o))
		else $error("stop release not joint");
	c_word_end: cover property ($rose(kb_request_o) && $rose(kb_serial_data_o));
	c_timeout: cover property (low_q == TIMEOUT_CYCLES);
	c_irq: cover property ($rose(irq_o));
endmodule : kb_link_chk

bind kb_link_top kb_link_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.ce_i(ce_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .host_ack_i(host_ack_i),
	.kb_request_o(kb_request_o), .kb_serial_data_o(kb_serial_data_o));

// *** tb/host_model.sv ***
/*
 behavioural host end of the link, collecting nine-bit words.
 assumes link_clk_i is unrelated to the block clock; mute_i may rise in the middle of a word.
*/
module host_model
(
	// link clock, reset, stall
	input  wire logic  link_clk_i,
	input  wire logic  rst_i,
	input  wire logic  mute_i,
	// link pins
	input  wire logic  req_i,
	input  wire logic  data_i,
	output logic       ack_o,
	// received words
	output logic [8:0] word_o,
	output int         words_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] shift_q;
	logic [3:0] bits_q;
	always_ff @(posedge link_clk_i or posedge rst_i)
		if (rst_i)
		begin
			ack_o   <= 1'b1;
			bits_q  <= 4'h0;
			words_o <= 0;
			word_o  <= 9'h0;
		end
		else if (!ack_o && req_i)
		begin
			ack_o  <= 1'b1;
			bits_q <= (bits_q == 4'h8) ? 4'h0 : bits_q + 4'h1;
			if (bits_q == 4'h8)
			begin
				word_o  <= shift_q;
				words_o <= words_o + 1;
			end
		end
		// a stalled host drops its partial word, as a real one resyncs
		else if (mute_i)
			bits_q <= 4'h0;
		else if (ack_o && !req_i)
		begin
			shift_q <= {data_i, shift_q[8:1]};
			ack_o   <= 1'b0;
		end
endmodule : host_model

// *** tb/tb_kb_link_top.sv ***
/*
 self-checking bench for kb_link_top against a behavioural host.
 assumes the package, the design and host_model are compiled first.
*/
module tb_kb_link_top;
	timeunit 1ns;
	timeprecision 1ns;
	import kb_link_pkg::*;
	localparam int unsigned TMO = 200;
	logic        clk_i;
	logic        rst_i;
	logic        link_clk;
	logic        mute;
	logic        ce;
	wb_req_s     wb_i;
	logic        wb_ack_o;
	logic [31:0] wb_dat_o;
	logic        irq_o;
	logic        host_ack;
	logic        kb_request_o;
	logic        kb_serial_data_o;
	logic [8:0]  word;
	int          words;
	int          miscompares = 0;
	int          checked = 0;
	int          cycles = 0;
	logic [31:0] rd;
	kb_link_top #(.TIMEOUT_CYCLES(TMO)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb_i),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o), .host_ack_i(host_ack),
		.kb_request_o(kb_request_o), .kb_serial_data_o(kb_serial_data_o));
	host_model host_u (.link_clk_i(link_clk), .rst_i(rst_i), .mute_i(mute), .req_i(kb_request_o),
		.data_i(kb_serial_data_o), .ack_o(host_ack), .word_o(word), .words_o(words));
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #200 link_clk = ~link_clk;
	end
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares = miscompares + 1;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] want, input logic [31:0] got);
		checked = checked + 1;
		if (got !== want)
		begin
			$display("unexpected %s expected %h seen %h", what, want, got);
			miscompares = miscompares + 1;
		end
	endtask : chk
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		wb_i <= '{1'b1, 1'b1, we, 4'hf, adr, dat};
		// no local limit: only the bench timeout ends a stuck wait
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_i <= '0;
		@(posedge clk_i);
	endtask : bus
	task automatic wait_words(input int n);
		repeat (3000)
			if (words < n)
				@(posedge clk_i);
		chk("word count", n, words);
	endtask : wait_words
	task automatic t_reset();
		chk("idle pins", 32'h3, {30'h0, kb_request_o, kb_serial_data_o});
		bus(1'b0, REG_CTRL, 32'h0);
		chk("ctrl reset", 32'h1, rd);
		bus(1'b0, REG_IRQ_MASK, 32'h0);
		chk("mask reset", 32'h0, rd);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped read", 32'h0, rd);
	endtask : t_reset
	task automatic t_freeze();
		ce <= 1'b0;
		fork
			bus(1'b0, REG_CTRL, 32'h0);
			begin
				repeat (6) @(posedge clk_i);
				chk("frozen ack", 32'h0, {31'h0, wb_ack_o});
				ce <= 1'b1;
			end
		join
		chk("ctrl after freeze", 32'h1, rd);
	endtask : t_freeze
	task automatic t_words();
		int n;
		n = words;
		bus(1'b1, REG_EVENT, 32'h85);
		bus(1'b1, REG_EVENT, 32'h05);
		wait_words(n + 1);
		chk("close word", 32'h085, {23'h0, word});
		wait_words(n + 2);
		chk("open word", 32'h005, {23'h0, word});
		repeat (20) @(posedge clk_i);
		chk("idle after stop", 32'h3, {30'h0, kb_request_o, kb_serial_data_o});
		chk("masked irq", 32'h0, {31'h0, irq_o});
		bus(1'b0, REG_IRQ_STAT, 32'h0);
		chk("sent flag", 32'h1, rd);
		bus(1'b0, REG_IRQ_STAT, 32'h0);
		chk("flag cleared", 32'h0, rd);
	endtask : t_words
	task automatic t_irq();
		int n;
		n = words;
		bus(1'b1, REG_IRQ_MASK, 32'h1);
		bus(1'b1, REG_EVENT, 32'h7f);
		wait_words(n + 1);
		chk("open key word", 32'h07f, {23'h0, word});
		repeat (10) @(posedge clk_i);
		chk("irq raised", 32'h1, {31'h0, irq_o});
		bus(1'b0, REG_IRQ_STAT, 32'h0);
		chk("irq status", 32'h1, rd);
		repeat (3) @(posedge clk_i);
		chk("irq dropped", 32'h0, {31'h0, irq_o});
		bus(1'b1, REG_IRQ_MASK, 32'h0);
	endtask : t_irq
	task automatic t_timeout();
		int n;
		n = words;
		bus(1'b1, REG_EVENT, 32'hc6);
		repeat (60) @(posedge clk_i);
		mute <= 1'b1;
		repeat (TMO * 2 + 60) @(posedge clk_i);
		bus(1'b0, REG_IRQ_STAT, 32'h0);
		chk("timeout flag", 32'h2, rd & 32'h2);
		mute <= 1'b0;
		wait_words(n + 1);
		chk("restarted word", 32'h0c6, {23'h0, word});
	endtask : t_timeout
	task automatic t_reserved();
		int n;
		n = words;
		bus(1'b1, REG_EVENT, 32'hfe);
		bus(1'b1, REG_CTRL, 32'h3);
		wait_words(n + 1);
		chk("dead word", 32'h0ff, {23'h0, word});
		repeat (600) @(posedge clk_i);
		chk("no extra word", n + 1, words);
	endtask : t_reserved
	task automatic t_overflow();
		int n;
		n = words;
		bus(1'b1, REG_CTRL, 32'h0);
		repeat (9) bus(1'b1, REG_EVENT, 32'h11);
		bus(1'b0, REG_STATUS, 32'h0);
		chk("full status", 32'h80000111, rd);
		bus(1'b0, REG_IRQ_STAT, 32'h0);
		chk("overflow flag", 32'h4, rd & 32'h4);
		bus(1'b1, REG_CTRL, 32'h1);
		wait_words(n + 1);
		chk("overflow word", 32'h0fe, {23'h0, word});
		wait_words(n + 9);
		chk("last queued word", 32'h011, {23'h0, word});
	endtask : t_overflow
	initial
	begin
		rst_i = 1'b1;
		mute = 1'b0;
		ce = 1'b1;
		wb_i = '0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_freeze();
		t_words();
		t_irq();
		t_timeout();
		t_reserved();
		t_overflow();
		tally_and_finish();
	end
endmodule : tb_kb_link_top
